/* File: common/snapshot_pkg.sv */
// Purpose: Shared constants and carriers for the motor status snapshot
// Assumes: 32-bit APB register words, byte addresses
// Notes:   Flag masks are bit positions inside the 32-bit flags word
package snapshot_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] CONFIG_OFS     = 8'h04;
  localparam logic [7:0] SUPPLY_V_OFS   = 8'h08;
  localparam logic [7:0] SUPPLY_I_OFS   = 8'h0c;
  localparam logic [7:0] HOST_V_OFS     = 8'h10;
  localparam logic [7:0] HOST_I_OFS     = 8'h14;
  localparam logic [7:0] TEMP_MAX_OFS   = 8'h18;
  localparam logic [7:0] TRACK_LIM_OFS  = 8'h1c;
  localparam logic [7:0] VALUE_LIM_OFS  = 8'h20;
  localparam logic [7:0] SNAP_STATE_OFS = 8'h40;
  localparam logic [7:0] SNAP_STEP_OFS  = 8'h44;
  localparam logic [7:0] SNAP_USTEP_OFS = 8'h48;
  localparam logic [7:0] SNAP_ENCLO_OFS = 8'h4c;
  localparam logic [7:0] SNAP_ENCHI_OFS = 8'h50;
  localparam logic [7:0] SNAP_SPEED_OFS = 8'h54;
  localparam logic [7:0] SNAP_FRAC_OFS  = 8'h58;
  localparam logic [7:0] SNAP_MCUR_OFS  = 8'h5c;
  localparam logic [7:0] SNAP_SVOLT_OFS = 8'h60;
  localparam logic [7:0] SNAP_HCUR_OFS  = 8'h64;
  localparam logic [7:0] SNAP_HVOLT_OFS = 8'h68;
  localparam logic [7:0] SNAP_TEMP_OFS  = 8'h6c;
  localparam logic [7:0] SNAP_FLAGS_OFS = 8'h70;

  // Control and config register bits
  localparam int CTRL_QUERY_BIT = 0;
  localparam int CTRL_VALID_BIT = 1;
  localparam int CFG_PRIO_BIT   = 0;

  // Reset values of the limit registers
  localparam logic [31:0] SUPPLY_V_RST  = 32'h0fa0_03e8;
  localparam logic [31:0] SUPPLY_I_RST  = 32'h0000_0bb8;
  localparam logic [31:0] HOST_V_RST    = 32'h0226_01c2;
  localparam logic [31:0] HOST_I_RST    = 32'h0000_01f4;
  localparam logic [31:0] TEMP_MAX_RST  = 32'h0000_02ee;
  localparam logic [31:0] TRACK_LIM_RST = 32'h0000_0100;
  localparam logic [31:0] VALUE_LIM_RST = 32'h7fff_8000;

  // Encoder condition codes
  localparam logic [7:0] ENCODER_MISSING_CODE       = 8'h00;
  localparam logic [7:0] ENCODER_INDETERMINATE_CODE = 8'h01;
  localparam logic [7:0] ENCODER_FAULTY_CODE        = 8'h02;
  localparam logic [7:0] ENCODER_REVERSED_CODE      = 8'h03;
  localparam logic [7:0] ENCODER_HEALTHY_CODE       = 8'h04;

  // Winding nibble codes, same for both coils
  localparam logic [3:0] COIL_OPEN    = 4'h0;
  localparam logic [3:0] COIL_UNKNOWN = 4'h1;
  localparam logic [3:0] COIL_SHORTED = 4'h2;
  localparam logic [3:0] COIL_HEALTHY = 4'h3;

  // Flags word
  localparam logic [31:0] CONTROLLER_STATE_GROUP  = 32'h0000_003f;
  localparam logic [31:0] UNKNOWN_COMMAND_FLAG    = 32'h0000_0001;
  localparam logic [31:0] CHECKSUM_MISMATCH_FLAG  = 32'h0000_0002;
  localparam logic [31:0] VALUE_CLAMPED_FLAG      = 32'h0000_0004;
  localparam logic [31:0] MEMORY_ATTACHED_FLAG    = 32'h0000_0010;
  localparam logic [31:0] CALIBRATED_FLAG         = 32'h0000_0020;
  localparam logic [31:0] PROTECTION_GROUP        = 32'h01b3_ffc0;
  localparam logic [31:0] ALARM_FLAG              = 32'h0000_0040;
  localparam logic [31:0] POSITION_TRACKING_ERROR = 32'h0000_0080;
  localparam logic [31:0] DRIVER_OVERHEAT_FLAG    = 32'h0000_0100;
  localparam logic [31:0] CONTROLLER_HOT_FLAG     = 32'h0000_0200;
  localparam logic [31:0] SUPPLY_OVERVOLTAGE      = 32'h0000_0400;
  localparam logic [31:0] SUPPLY_OVERCURRENT      = 32'h0000_0800;
  localparam logic [31:0] HOST_PORT_OVERVOLTAGE   = 32'h0000_1000;
  localparam logic [31:0] HOST_PORT_UNDERVOLTAGE  = 32'h0000_2000;
  localparam logic [31:0] HOST_PORT_OVERCURRENT   = 32'h0000_4000;
  localparam logic [31:0] LIMIT_ORIENTATION_FAULT = 32'h0000_8000;
  localparam logic [31:0] SUPPLY_UNDERVOLTAGE     = 32'h0001_0000;

  // Raw condition of encoder and coils
  typedef struct packed {
    logic encoder_present;
    logic encoder_fault;
    logic encoder_unknown;
    logic encoder_reversed;
    logic coil_a_open;
    logic coil_a_short;
    logic coil_a_unknown;
    logic coil_b_open;
    logic coil_b_short;
    logic coil_b_unknown;
  } sensor_t;

  // Motion state
  typedef struct packed {
    logic signed [31:0] step_position;
    logic signed [15:0] microstep_position;
    logic signed [63:0] encoder_count;
    logic signed [31:0] shaft_speed;
    logic signed [15:0] shaft_speed_fraction;
  } motion_t;

  // Telemetry, mA, 10 mV and 0.1 degC units
  typedef struct packed {
    logic signed [15:0] motor_current;
    logic signed [15:0] supply_voltage;
    logic signed [15:0] host_current;
    logic signed [15:0] host_voltage;
    logic signed [15:0] temperature_decidegree;
  } telemetry_t;

  // One decoded command from the link
  typedef struct packed {
    logic               valid;
    logic               known;
    logic               checksum_ok;
    logic               is_stop;
    logic signed [15:0] value;
  } command_t;

  // Captured snapshot
  typedef struct packed {
    logic [7:0]  encoder_condition;
    logic [7:0]  winding_condition;
    motion_t     motion;
    telemetry_t  telemetry;
    logic [31:0] flags;
  } snapshot_t;

endpackage

/* File: hw/motor_status_snapshot.sv */
// Purpose: Status snapshot and flags of a motor controller, APB slave
// Assumes: All inputs synchronous to pclk; zero-wait decode, one wait
// Notes:   Error flags are sticky until the next snapshot capture
//
// Summary of operation
// RULE1 - Encoder reversed reads 0x3, healthy encoder reads 0x4.
// RULE2 - Encoder missing reads 0x0, indeterminate 0x1, faulty 0x2.
// RULE3 - Coil A condition sits in low nibble: open, unknown, short, ok.
// RULE4 - Coil B condition sits in high nibble, same codes shifted.
// RULE5 - Signed microstep position is reported, meaningful for steppers.
// RULE6 - Speed in whole steps plus signed microstep fraction for steppers.
// RULE7 - Currents in mA, voltages 10 mV, temperature 0.1 degC, signed.
// RULE8 - Unknown command code sets flag bit 0x1.
// RULE9 - Checksum mismatch sets flag 0x2 and the payload is dropped.
// RULE10 - Out-of-range value is clamped, applied, and flag 0x4 set.
// RULE11 - Flag 0x10 while memory attached; profile load needs priority.
// RULE12 - Calibrated flag 0x20 set on homing, cleared on lost calibration.
// RULE13 - Alarm 0x40 ignores most commands; only a stop clears it.
// RULE14 - Stepper tracking error over the limit sets flag 0x80.
// RULE15 - Driver overheat sets 0x100 and disables motor until cooled; here the disable lasts until a stop clears the alarm.
// RULE16 - Controller hot 0x200, supply overvoltage 0x400, overcurrent 0x800.
// RULE17 - Host port overvoltage 0x1000, undervoltage 0x2000, current 0x4000.
// RULE18 - Stuck at the wrong limit sets flag 0x8000.
// RULE19 - Supply below low-voltage threshold sets flag 0x10000.
// RULE20 - A query returns one snapshot with motion and all flags.
// RULE21 - All snapshot fields are captured in one clock cycle.
`timescale 1ns/1ps
module motor_status_snapshot
  import snapshot_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire sensor_t            sensor,
  input  wire motion_t            motion,
  input  wire telemetry_t         telemetry,
  input  wire command_t           command,
  input  wire logic               stepper_mode,
  input  wire logic               memory_attached,
  input  wire logic               homing_done,
  input  wire logic               calibration_lost,
  input  wire logic               driver_hot,
  input  wire logic               wrong_limit_stuck,
  output logic                    command_accept,
  output logic signed [15:0]      applied_value,
  output logic                    motor_disable,
  output logic                    profile_load_enable
);

  logic        pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic        query_reg, valid_reg;
  logic [31:0] config_reg;
  logic [31:0] supply_v_reg, supply_i_reg;
  logic [31:0] host_v_reg, host_i_reg;
  logic [31:0] temp_max_reg, track_lim_reg, value_lim_reg;
  logic [2:0]  error_reg;
  logic        calibrated_reg, alarm_reg;
  logic [31:0] flags_reg, flags_next;
  snapshot_t   snap_reg;
  logic        accept_reg;
  logic signed [15:0] applied_reg;
  logic        disable_reg, profile_reg;
  logic [7:0]  encoder_condition, winding_condition;
  logic        bus_write, bus_hit;
  logic [31:0] read_next;
  logic        cmd_good, cmd_stop, cmd_low, cmd_high;

  // Absolute distance of two signed words
  function automatic logic [31:0] distance(input logic signed [31:0] a,
                                           input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'(a) - 33'(b);
    return d[32] ? 32'(-d) : d[31:0];
  endfunction

  // Coil nibble from raw coil condition
  function automatic logic [3:0] coil_code(input logic open,
                                           input logic short,
                                           input logic unknown);
    return open ? COIL_OPEN : short ? COIL_SHORTED :
           unknown ? COIL_UNKNOWN : COIL_HEALTHY;
  endfunction

  // RULE1 RULE2 encoder code
  always_comb begin
    if (!sensor.encoder_present) encoder_condition = ENCODER_MISSING_CODE;
    else if (sensor.encoder_fault)     encoder_condition = ENCODER_FAULTY_CODE;
    else if (sensor.encoder_unknown) begin
      encoder_condition = ENCODER_INDETERMINATE_CODE;
    end else if (sensor.encoder_reversed) begin
      encoder_condition = ENCODER_REVERSED_CODE;
    end else encoder_condition = ENCODER_HEALTHY_CODE;
  end

  // RULE3 RULE4 coil nibbles
  assign winding_condition = {
    coil_code(sensor.coil_b_open, sensor.coil_b_short, sensor.coil_b_unknown),
    coil_code(sensor.coil_a_open, sensor.coil_a_short, sensor.coil_a_unknown)};

  // APB decode
  assign bus_write = psel && penable && pready_reg && pwrite;
  assign bus_hit   = (paddr <= VALUE_LIM_OFS) ||
                     (paddr >= SNAP_STATE_OFS && paddr <= SNAP_FLAGS_OFS);

  // Read mux over the register map
  always_comb begin
    read_next = 32'h0000_0000;
    case (paddr)
      CTRL_OFS:       read_next = {30'h0, valid_reg, query_reg};
      CONFIG_OFS:     read_next = config_reg;
      SUPPLY_V_OFS:   read_next = supply_v_reg;
      SUPPLY_I_OFS:   read_next = supply_i_reg;
      HOST_V_OFS:     read_next = host_v_reg;
      HOST_I_OFS:     read_next = host_i_reg;
      TEMP_MAX_OFS:   read_next = temp_max_reg;
      TRACK_LIM_OFS:  read_next = track_lim_reg;
      VALUE_LIM_OFS:  read_next = value_lim_reg;
      SNAP_STATE_OFS: read_next = {16'h0, snap_reg.winding_condition,
                                   snap_reg.encoder_condition};
      SNAP_STEP_OFS:  read_next = snap_reg.motion.step_position;
      SNAP_USTEP_OFS: read_next = 32'(snap_reg.motion.microstep_position);
      SNAP_ENCLO_OFS: read_next = snap_reg.motion.encoder_count[31:0];
      SNAP_ENCHI_OFS: read_next = snap_reg.motion.encoder_count[63:32];
      SNAP_SPEED_OFS: read_next = snap_reg.motion.shaft_speed;
      SNAP_FRAC_OFS:  read_next = 32'(snap_reg.motion.shaft_speed_fraction);
      SNAP_MCUR_OFS:  read_next = 32'(snap_reg.telemetry.motor_current);
      SNAP_SVOLT_OFS: read_next = 32'(snap_reg.telemetry.supply_voltage);
      SNAP_HCUR_OFS:  read_next = 32'(snap_reg.telemetry.host_current);
      SNAP_HVOLT_OFS: read_next = 32'(snap_reg.telemetry.host_voltage);
      SNAP_TEMP_OFS:  read_next =
                        32'(snap_reg.telemetry.temperature_decidegree);
      SNAP_FLAGS_OFS: read_next = snap_reg.flags;
      default:        read_next = 32'h0000_0000;
    endcase
  end

  // APB answer, one wait state in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      prdata_reg  <= (psel && penable && !pwrite) ? read_next : 32'h0000_0000;
      pslverr_reg <= psel && penable && !pready_reg && !bus_hit;
    end
  end

  // Software limit and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg    <= 32'h0000_0000;
      supply_v_reg  <= SUPPLY_V_RST;
      supply_i_reg  <= SUPPLY_I_RST;
      host_v_reg    <= HOST_V_RST;
      host_i_reg    <= HOST_I_RST;
      temp_max_reg  <= TEMP_MAX_RST;
      track_lim_reg <= TRACK_LIM_RST;
      value_lim_reg <= VALUE_LIM_RST;
    end else if (bus_write) begin
      case (paddr)
        CONFIG_OFS:    config_reg    <= pwdata;
        SUPPLY_V_OFS:  supply_v_reg  <= pwdata;
        SUPPLY_I_OFS:  supply_i_reg  <= pwdata;
        HOST_V_OFS:    host_v_reg    <= pwdata;
        HOST_I_OFS:    host_i_reg    <= pwdata;
        TEMP_MAX_OFS:  temp_max_reg  <= pwdata;
        TRACK_LIM_OFS: track_lim_reg <= pwdata;
        VALUE_LIM_OFS: value_lim_reg <= pwdata;
        default:       config_reg    <= config_reg;
      endcase
    end
  end

  // Query strobe, self-clearing; valid sticks after first capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      query_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      query_reg <= bus_write && paddr == CTRL_OFS && pwdata[CTRL_QUERY_BIT];
      if (query_reg) valid_reg <= 1'b1;
    end
  end

  // Command screening
  assign cmd_good = command.valid && command.known && command.checksum_ok;
  assign cmd_stop = cmd_good && command.is_stop;
  assign cmd_low  = command.value < $signed(value_lim_reg[15:0]);
  assign cmd_high = command.value > $signed(value_lim_reg[31:16]);

  // RULE13 alarm gate, RULE9 drop bad payload, RULE10 clamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_reg  <= 1'b0;
      applied_reg <= 16'sh0000;
    end else begin
      accept_reg <= cmd_good && (!alarm_reg || command.is_stop);
      if (cmd_good && (!alarm_reg || command.is_stop)) begin
        applied_reg <= cmd_high ? $signed(value_lim_reg[31:16]) :
                       cmd_low  ? $signed(value_lim_reg[15:0]) :
                                  command.value;
      end
    end
  end

  // RULE8 RULE9 RULE10 sticky errors, set wins over capture clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_reg <= 3'h0;
    end else begin
      error_reg <= (query_reg ? 3'h0 : error_reg) |
                   {cmd_good && (cmd_low || cmd_high),
                    command.valid && command.known && !command.checksum_ok,
                    command.valid && !command.known};
    end
  end

  // RULE12 calibration state, homing wins over loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) calibrated_reg <= 1'b0;
    else if (homing_done) calibrated_reg <= 1'b1;
    else if (calibration_lost) calibrated_reg <= 1'b0;
  end

  // Live flags word
  always_comb begin
    flags_next = 32'h0000_0000;
    // RULE8 RULE9 RULE10 error bits
    flags_next[2:0] = error_reg;
    // RULE11 memory presence
    if (memory_attached) flags_next |= MEMORY_ATTACHED_FLAG;
    if (calibrated_reg)  flags_next |= CALIBRATED_FLAG;
    if (alarm_reg)       flags_next |= ALARM_FLAG;
    // RULE14 tracking error, steppers only
    if (stepper_mode && distance(motion.encoder_count[31:0],
                                 motion.step_position) > track_lim_reg)
      flags_next |= POSITION_TRACKING_ERROR;
    // RULE15 driver overheat
    if (driver_hot) flags_next |= DRIVER_OVERHEAT_FLAG;
    // RULE16 controller and supply limits
    if (telemetry.temperature_decidegree > $signed(temp_max_reg[15:0]))
      flags_next |= CONTROLLER_HOT_FLAG;
    if (telemetry.supply_voltage > $signed(supply_v_reg[31:16]))
      flags_next |= SUPPLY_OVERVOLTAGE;
    if (telemetry.motor_current > $signed(supply_i_reg[15:0]))
      flags_next |= SUPPLY_OVERCURRENT;
    // RULE17 host port limits
    if (telemetry.host_voltage > $signed(host_v_reg[31:16]))
      flags_next |= HOST_PORT_OVERVOLTAGE;
    if (telemetry.host_voltage < $signed(host_v_reg[15:0]))
      flags_next |= HOST_PORT_UNDERVOLTAGE;
    if (telemetry.host_current > $signed(host_i_reg[15:0]))
      flags_next |= HOST_PORT_OVERCURRENT;
    // RULE18 wrong limit
    if (wrong_limit_stuck) flags_next |= LIMIT_ORIENTATION_FAULT;
    // RULE19 low supply voltage
    if (telemetry.supply_voltage < $signed(supply_v_reg[15:0]))
      flags_next |= SUPPLY_UNDERVOLTAGE;
  end

  // RULE13 alarm latch, a new hazard wins over the stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) alarm_reg <= 1'b0;
    else if (|(flags_next & PROTECTION_GROUP & ~ALARM_FLAG)) alarm_reg <= 1'b1;
    else if (cmd_stop) alarm_reg <= 1'b0;
  end

  // Flags word and motor side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg   <= 32'h0000_0000;
      disable_reg <= 1'b0;
      profile_reg <= 1'b0;
    end else begin
      flags_reg   <= flags_next;
      // RULE15 hold the motor off while hot
      disable_reg <= driver_hot || alarm_reg;
      // RULE11 profile load needs priority
      profile_reg <= memory_attached && config_reg[CFG_PRIO_BIT];
    end
  end

  // RULE20 RULE21 one-cycle capture of every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_reg <= '0;
    end else if (query_reg) begin
      snap_reg.encoder_condition <= encoder_condition;
      snap_reg.winding_condition <= winding_condition;
      // RULE5 RULE6 motion fields
      snap_reg.motion            <= motion;
      // RULE7 telemetry fields
      snap_reg.telemetry         <= telemetry;
      snap_reg.flags             <= flags_next;
    end
  end

  assign pready              = pready_reg;
  assign prdata              = prdata_reg;
  assign pslverr             = pslverr_reg;
  assign command_accept      = accept_reg;
  assign applied_value       = applied_reg;
  assign motor_disable       = disable_reg;
  assign profile_load_enable = profile_reg;

  // Checks, all on pclk and quiet during reset
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence bad_code_s;
    command.valid && !command.known;
  endsequence
  sequence clamp_high_s;
    cmd_good && !alarm_reg && cmd_high;
  endsequence

  enc_rev_code_a: assert property ( // RULE1
    query_reg && sensor.encoder_present && !sensor.encoder_fault &&
    !sensor.encoder_unknown && sensor.encoder_reversed
    |=> snap_reg.encoder_condition == 8'h03)
    else $error("reversed encoder code wrong");
  enc_missing_a: assert property ( // RULE2
    query_reg && !sensor.encoder_present
    |=> snap_reg.encoder_condition == 8'h00)
    else $error("missing encoder code wrong");
  coil_a_short_a: assert property ( // RULE3
    query_reg && !sensor.coil_a_open && sensor.coil_a_short
    |=> snap_reg.winding_condition[3:0] == 4'h2)
    else $error("coil A short code wrong");
  coil_b_ok_a: assert property ( // RULE4
    query_reg && !sensor.coil_b_open && !sensor.coil_b_short &&
    !sensor.coil_b_unknown |=> snap_reg.winding_condition[7:4] == 4'h3)
    else $error("coil B healthy code wrong");
  unknown_cmd_a: assert property ( // RULE8
    bad_code_s |=> error_reg[0] ##1 flags_reg[0])
    else $error("unknown command flag missing");
  clamp_apply_a: assert property ( // RULE10
    clamp_high_s |=> applied_reg == $signed(value_lim_reg[31:16]) &&
    accept_reg ##1 flags_reg[2])
    else $error("clamp not applied");
  alarm_ignore_a: assert property ( // RULE13
    alarm_reg && command.valid && !command.is_stop |=> !accept_reg)
    else $error("command taken during alarm");
  driver_hot_a: assert property ( // RULE15
    driver_hot |=> motor_disable && flags_reg[8])
    else $error("overheat not handled");
  low_supply_a: assert property ( // RULE19
    telemetry.supply_voltage < $signed(supply_v_reg[15:0]) |=> flags_reg[16])
    else $error("low supply flag missing");
  snap_atomic_a: assert property ( // RULE21
    query_reg |=> snap_reg.motion == $past(motion) &&
    snap_reg.telemetry == $past(telemetry))
    else $error("snapshot fields not captured together");

endmodule

/* File: dv/cmd_host.sv */
// Purpose: Host end of the command link
// Assumes: fire pulses one cycle per command
// Notes:   Idle payload toggles so stale data never looks valid
`timescale 1ns/1ps
module cmd_host
  import snapshot_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     fire,
  input  wire command_t req,
  output command_t      command
);
  initial command = '0;
  always @(posedge pclk) begin
    command <= fire ? req : {1'b0, ~command[18:0]};
  end
endmodule

/* File: dv/testbench.sv */
// Purpose: Self-checking bench of the status snapshot
// Assumes: One pclk domain, APB master in tasks
// Notes:   Reads and accepts are checked from queues
`timescale 1ns/1ps
module testbench import snapshot_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic stepper_mode = 1, memory_attached = 0, homing_done = 0;
  logic calibration_lost = 0, driver_hot = 0, wrong_limit_stuck = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, command_accept, motor_disable, profile_load_enable;
  logic signed [15:0] applied_value;
  sensor_t sensor = '0;
  motion_t motion = '0;
  telemetry_t telemetry = '0;
  command_t req = '0, command;
  logic [32:0] exp_rd [$], exp_v [$];
  int fails = 0, cmp_count = 0;
  motor_status_snapshot uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .sensor, .motion,
    .telemetry, .command, .stepper_mode, .memory_attached, .homing_done,
    .calibration_lost, .driver_hot, .wrong_limit_stuck, .command_accept,
    .applied_value, .motor_disable, .profile_load_enable);
  cmd_host host (.pclk, .fire, .req, .command);
  initial forever #2.5 pclk = ~pclk;
  task automatic chk(string n, logic [32:0] e, logic [32:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Setup, access until pready, release, one idle edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Sends v; x is what must be applied once clamped
  task automatic send(logic k, ok, s, logic signed [15:0] v, x,
                      logic acc);
    if (acc) exp_v.push_back(33'(x));
    fire <= 1'b1;
    req <= '{1'b1, k, ok, s, v};
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic safe;
    telemetry <= {16'd100, 16'd2000, 16'd100, 16'd500, 16'd250};
    motion <= '0;
    driver_hot <= 1'b0;
    wrong_limit_stuck <= 1'b0;
  endtask
  // Result watcher takes the oldest note per answer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", exp_rd.pop_front(), {pslverr, prdata});
    if (command_accept === 1'b1)
      chk("applied", exp_v.pop_front(), 33'(applied_value));
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end
  initial begin
    motion_t m;
    telemetry_t t;
    logic [32:0] e;
    logic [31:0] ex [12];
    logic [9:0] st [5] = '{10'h024, 10'h352, 10'h2c9, 10'h240, 10'h202};
    logic [15:0] ew [5] = '{16'h0, 16'h2202, 16'h1101, 16'h3303, 16'h2304};
    logic [31:0] hf [10] = '{DRIVER_OVERHEAT_FLAG, CONTROLLER_HOT_FLAG,
      SUPPLY_OVERVOLTAGE, SUPPLY_OVERCURRENT, HOST_PORT_OVERVOLTAGE,
      HOST_PORT_UNDERVOLTAGE, HOST_PORT_OVERCURRENT,
      LIMIT_ORIENTATION_FAULT, SUPPLY_UNDERVOLTAGE, POSITION_TRACKING_ERROR};
    void'($urandom(56));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SUPPLY_V_OFS, {1'b0, SUPPLY_V_RST});
    rd(8'h3c, 33'h1_0000_0000);
    // Inputs move right after capture; reads must show captured values
    for (int i = 0; i < 5; i++) begin
      m = {$urandom, $urandom, $urandom, $urandom, $urandom};
      t = 80'({$urandom, $urandom, $urandom});
      sensor <= st[i];
      motion <= m;
      telemetry <= t;
      @(posedge pclk);
      apb(1'b1, CTRL_OFS, 32'h1);
      sensor <= ~st[i];
      motion <= ~m;
      telemetry <= ~t;
      ex = '{{16'h0, ew[i]}, m.step_position, 32'(m.microstep_position),
        m.encoder_count[31:0], m.encoder_count[63:32], m.shaft_speed,
        32'(m.shaft_speed_fraction), 32'(t.motor_current),
        32'(t.supply_voltage), 32'(t.host_current), 32'(t.host_voltage),
        32'(t.temperature_decidegree)};
      rd(SNAP_STATE_OFS, {1'b0, ex[0]});
      for (int k = 1; k < 7; k++)
        rd(8'(8'h40 + 4 * k), {1'b0, ex[k]});
      for (int k = 7; k < 12; k++)
        rd(8'(8'h40 + 4 * k), {1'b0, ex[k]});
    end
    // One hazard at a time, alarm cleared by stop in between
    for (int i = 0; i < 10; i++) begin
      safe();
      @(posedge pclk);
      send(1'b1, 1'b1, 1'b1, 16'sd0, 16'sd0, 1'b1);
      case (i)
        0: driver_hot <= 1'b1;
        1: telemetry.temperature_decidegree <= 16'sd751;
        2: telemetry.supply_voltage <= 16'sd4001;
        3: telemetry.motor_current <= 16'sd3001;
        4: telemetry.host_voltage <= 16'sd551;
        5: telemetry.host_voltage <= 16'sd449;
        6: telemetry.host_current <= 16'sd501;
        7: wrong_limit_stuck <= 1'b1;
        8: telemetry.supply_voltage <= 16'sd999;
        default: motion.encoder_count <= 64'sd257;
      endcase
      @(posedge pclk);
      send(1'b1, 1'b1, 1'b0, 16'sd5, 16'sd5, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h1);
      e = {1'b0, hf[i] | ALARM_FLAG};
      rd(SNAP_FLAGS_OFS, e);
      chk("disable", 33'h1, 33'(motor_disable));
    end
    safe();
    @(posedge pclk);
    send(1'b1, 1'b1, 1'b1, 16'sd0, 16'sd0, 1'b1);
    apb(1'b1, VALUE_LIM_OFS, 32'h0064_ff9c);
    send(1'b1, 1'b1, 1'b0, 16'sd300, 16'sd100, 1'b1);
    send(1'b1, 1'b1, 1'b0, -16'sd300, -16'sd100, 1'b1);
    send(1'b0, 1'b1, 1'b0, 16'sd1, 16'sd0, 1'b0);
    send(1'b1, 1'b0, 1'b0, 16'sd1, 16'sd0, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h1);
    rd(SNAP_FLAGS_OFS, 33'h7);
    chk("disable", 33'h0, 33'(motor_disable));
    memory_attached <= 1'b1;
    homing_done <= 1'b1;
    @(posedge pclk);
    homing_done <= 1'b0;
    apb(1'b1, CONFIG_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h1);
    rd(SNAP_FLAGS_OFS, 33'h30);
    chk("profile", 33'h1, 33'(profile_load_enable));
    memory_attached <= 1'b0;
    calibration_lost <= 1'b1;
    @(posedge pclk);
    calibration_lost <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h1);
    rd(SNAP_FLAGS_OFS, 33'h0);
    close_out();
  end
endmodule
